// [cies_core.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_core (
  input  wire logic                              clk_in,
  input  wire logic                              rst_b_in,
  input  wire logic [cies_pkg::INSTR_W-1:0]      instr_in,
  input  wire logic [cies_pkg::DATA_W-1:0]       freg_rdata_in,
  input  wire logic                              push_in,
  input  wire logic [cies_pkg::PC_W-1:0]         push_addr_in,
  input  wire logic                              wake_in,
  output logic [cies_pkg::PC_W-1:0]              pc_out,
  output logic [cies_pkg::ADDR_W-1:0]            freg_raddr_out,
  output cies_pkg::cies_fwrite_type              fwrite_out,
  output logic [cies_pkg::DATA_W-1:0]            acc_out,
  output cies_pkg::cies_flags_type               flags_out,
  output logic                                   global_irq_enable_out,
  output logic [cies_pkg::WDOG_W-1:0]            watchdog_counter_out,
  output logic [cies_pkg::PRE_W-1:0]             wdog_prescaler_out,
  output logic                                   halted_out
);
  import cies_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // the register file sits outside; freg_rdata_in is the value of the
  // address named by instr_in[6:0] in the same cycle (async read).
  cies_state_type        state_reg, state_next;
  logic [PC_W-1:0]       pc_reg, pc_next;
  logic [DATA_W-1:0]     acc_reg, acc_next;
  cies_flags_type        flags_reg, flags_next;
  logic                  irq_en_reg, irq_en_next;
  logic [WDOG_W-1:0]     wdog_reg;
  logic                  halted_reg;
  logic [PRE_W-1:0]      pre_reg;
  cies_fwrite_type       fw_reg, fw_next;
  logic [PC_W-1:0]       stack_mem [STACK_D];
  logic [SP_W-1:0]       sp_reg, sp_next;
  logic                  pop;
  logic                  sleep_now;
  logic [PC_W-1:0]       stack_top;

  function automatic logic [DATA_W-1:0] dest_sel(
    input logic [DATA_W-1:0] v);
    dest_sel = v;
  endfunction

  wire logic [5:0]        op6  = instr_in[OP_HI:OP_LO];
  wire logic              dbit = instr_in[D_BIT];
  wire logic [DATA_W-1:0] fval = freg_rdata_in;
  assign stack_top = stack_mem[sp_reg - 3'h1];

  // --------------------------------------------------------------
  // execute
  // --------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] res;
    logic              wr_f;
    logic              wr_acc;
    res        = fval;
    wr_f       = 1'b0;
    wr_acc     = 1'b0;
    state_next = state_reg;
    pc_next    = pc_reg;
    acc_next   = acc_reg;
    flags_next = flags_reg;
    irq_en_next = irq_en_reg;
    pop        = 1'b0;
    sleep_now  = 1'b0;
    unique case (state_reg)
      CIES_EXEC: begin
        pc_next = pc_reg + 11'h001;
        if (instr_in == IW_RETURN) begin
          pop        = 1'b1;
          pc_next    = stack_top;
          state_next = CIES_FLUSH;
        end else if (instr_in == IW_RET_IRQ) begin
          pop        = 1'b1;
          pc_next    = stack_top;
          irq_en_next = 1'b1;
          state_next = CIES_FLUSH;
        end else if (instr_in == IW_SLEEP) begin
          flags_next.timeout_status_n   = 1'b1;
          flags_next.powerdown_status_n = 1'b0;
          sleep_now  = 1'b1;
          state_next = CIES_HALT;
        end else if (instr_in[OP_HI:OP_HI-3] == OP_RETL) begin
          acc_next   = instr_in[DATA_W-1:0];
          pop        = 1'b1;
          pc_next    = stack_top;
          state_next = CIES_FLUSH;
        end else begin
          unique case (op6)
            OP_MOVE_OR_NOP: begin
              if (dbit) begin
                res  = acc_reg;
                wr_f = 1'b1;
              end
            end
            OP_IOR: begin
              res             = acc_reg | fval;
              flags_next.zero = (res == 8'h00);
              wr_f            = dbit;
              wr_acc          = !dbit;
            end
            OP_MOVE_REG: begin
              res             = fval;
              flags_next.zero = (res == 8'h00);
              wr_f            = dbit;
              wr_acc          = !dbit;
            end
            OP_RLC: begin
              res = {fval[BIT_MSB-1:0], flags_reg.carry};
              flags_next.carry = fval[BIT_MSB];
              wr_f   = dbit;
              wr_acc = !dbit;
            end
            OP_RRC: begin
              res = {flags_reg.carry, fval[BIT_MSB:1]};
              flags_next.carry = fval[0];
              wr_f   = dbit;
              wr_acc = !dbit;
            end
            default: begin
            end
          endcase
          if (wr_acc) begin
            acc_next = dest_sel(res);
          end
        end
      end
      CIES_FLUSH: begin
        state_next = CIES_EXEC; // second cycle of a return
      end
      CIES_HALT: begin
        pc_next = pc_reg;
        if (wake_in) begin
          state_next = CIES_EXEC;
        end
      end
      default: begin
        state_next = CIES_EXEC;
      end
    endcase
    fw_next.addr = instr_in[ADDR_W-1:0];
    fw_next.data = res;
    fw_next.we   = wr_f;
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= CIES_EXEC;
      pc_reg    <= PC_RESET;
      acc_reg   <= ACC_RESET;
      flags_reg <= '{carry: 1'b0, zero: 1'b0,
                     timeout_status_n: 1'b1, powerdown_status_n: 1'b1};
      irq_en_reg <= 1'b0;
      fw_reg    <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      flags_reg <= flags_next;
      irq_en_reg <= irq_en_next;
      fw_reg    <= fw_next;
    end
  end

  // watchdog: steps once every 256 cycles, on prescaler wrap, while not halted; cleared by sleep
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wdog_reg <= WDOG_CLEAR;
      pre_reg  <= PRE_CLEAR;
    end else if (sleep_now) begin
      wdog_reg <= WDOG_CLEAR;
      pre_reg  <= PRE_CLEAR;
    end else if (state_reg != CIES_HALT) begin
      pre_reg <= pre_reg + 8'h01;
      if (pre_reg == 8'hFF) begin
        wdog_reg <= wdog_reg + 8'h01;
      end
    end
  end

  // halt flag registered so the output carries no decode glitch
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      halted_reg <= 1'b0;
    end else begin
      halted_reg <= (state_next == CIES_HALT);
    end
  end

  // stack wraps like a ring; overflow silently overwrites the oldest
  always_comb begin
    sp_next = sp_reg;
    if (pop) begin
      sp_next = sp_reg - 3'h1;
    end else if (push_in) begin
      sp_next = sp_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sp_reg <= SP_RESET;
    end else begin
      sp_reg <= sp_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_in && !pop) begin
      stack_mem[sp_reg] <= push_addr_in;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign pc_out                = pc_reg;
  assign freg_raddr_out        = instr_in[ADDR_W-1:0];
  assign fwrite_out            = fw_reg;
  assign acc_out               = acc_reg;
  assign flags_out             = flags_reg;
  assign global_irq_enable_out = irq_en_reg;
  assign watchdog_counter_out  = wdog_reg;
  assign wdog_prescaler_out    = pre_reg;
  assign halted_out            = halted_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  wire logic exec_q = (state_reg == CIES_EXEC);

  sequence s_ret_issue;
    exec_q && (instr_in == IW_RETURN);
  endsequence
  sequence s_flush_then_exec;
    (state_reg == CIES_FLUSH) ##1 exec_q;
  endsequence

  a_ret_two_cycle: assert property (
    s_ret_issue |=> s_flush_then_exec)
    else $error("return did not take two cycles");
  a_ret_flags_kept: assert property (
    s_ret_issue |=> $stable(flags_reg))
    else $error("return changed flags");
  a_retl_acc_load: assert property (
    exec_q && instr_in[13:10] == OP_RETL
      |=> acc_reg == $past(instr_in[7:0]) && $stable(flags_reg))
    else $error("literal return bad accumulator");
  a_retl_pc_pop: assert property (
    exec_q && instr_in[13:10] == OP_RETL
      |=> pc_reg == $past(stack_top) ##1 exec_q)
    else $error("literal return bad pc");
  a_irq_ret_enable: assert property (
    exec_q && instr_in == IW_RET_IRQ |=> irq_en_reg)
    else $error("interrupt return left interrupts disabled");
  a_sleep_status: assert property (
    exec_q && instr_in == IW_SLEEP |=> flags_reg.timeout_status_n
      && !flags_reg.powerdown_status_n && wdog_reg == 8'h00
      && pre_reg == 8'h00)
    else $error("sleep status or watchdog wrong");
  a_halt_pc_frozen: assert property (
    state_reg == CIES_HALT |=> $stable(pc_reg))
    else $error("pc moved while halted");
  a_nop_pc_step: assert property (
    exec_q && instr_in == IW_NOP |=> pc_reg == $past(pc_reg) + 11'h001
      && $stable(acc_reg) && $stable(flags_reg) && !fw_reg.we)
    else $error("nop changed state");
  a_ior_zero_flag: assert property (
    exec_q && op6 == OP_IOR |=> flags_reg.zero ==
      (($past(acc_reg) | $past(fval)) == 8'h00))
    else $error("or zero flag wrong");
  a_rlc_carry: assert property (
    exec_q && op6 == OP_RLC |=> flags_reg.carry == $past(fval[7]))
    else $error("rotate left carry wrong");

  sequence s_irq_ret_issue;
    exec_q && (instr_in == IW_RET_IRQ);
  endsequence
  sequence s_sleep_issue;
    exec_q && (instr_in == IW_SLEEP);
  endsequence

  a_ret_pc_pop: assert property (
    s_ret_issue |=> pc_reg == $past(stack_top))
    else $error("return loaded wrong pc");
  a_ret_sp_pop: assert property (
    s_ret_issue |=> sp_reg == $past(sp_reg) - 3'h1)
    else $error("return did not pop the stack");
  a_irq_ret_pop: assert property (
    s_irq_ret_issue |=> pc_reg == $past(stack_top)
      && $stable(flags_reg) ##1 exec_q)
    else $error("interrupt return bad pc or flags");
  a_flush_no_write: assert property (
    state_reg == CIES_FLUSH |=> !fw_reg.we && $stable(acc_reg))
    else $error("flush cycle executed an instruction");
  a_store_data: assert property (
    exec_q && op6 == OP_MOVE_OR_NOP && dbit |=> fw_reg.we
      && fw_reg.data == $past(acc_reg)
      && fw_reg.addr == $past(instr_in[ADDR_W-1:0]) && $stable(flags_reg))
    else $error("store wrote wrong data or flags");
  a_move_zero: assert property (
    exec_q && op6 == OP_MOVE_REG |=> flags_reg.zero ==
      ($past(fval) == 8'h00) && $stable(flags_reg.carry))
    else $error("move zero flag wrong");
  a_move_dest: assert property (
    exec_q && op6 == OP_MOVE_REG && !dbit |=> acc_reg == $past(fval)
      && !fw_reg.we)
    else $error("move to accumulator wrong");
  a_ior_dest: assert property (
    exec_q && op6 == OP_IOR && dbit |=> fw_reg.we && $stable(acc_reg)
      && fw_reg.data == ($past(acc_reg) | $past(fval)))
    else $error("or to register wrong");
  a_rlc_result: assert property (
    exec_q && op6 == OP_RLC && !dbit |=> acc_reg ==
      {$past(fval[BIT_MSB-1:0]), $past(flags_reg.carry)})
    else $error("rotate left result wrong");
  a_rrc_carry: assert property (
    exec_q && op6 == OP_RRC |=> flags_reg.carry == $past(fval[0])
      && $stable(flags_reg.zero))
    else $error("rotate right carry wrong");
  a_rrc_result: assert property (
    exec_q && op6 == OP_RRC && !dbit |=> acc_reg ==
      {$past(flags_reg.carry), $past(fval[BIT_MSB:1])})
    else $error("rotate right result wrong");
  a_sleep_halts: assert property (
    s_sleep_issue |=> halted_reg)
    else $error("sleep did not halt");
  a_sleep_others_kept: assert property (
    s_sleep_issue |=> $stable(flags_reg.zero) && $stable(flags_reg.carry))
    else $error("sleep changed carry or zero");
  a_halt_no_write: assert property (
    state_reg == CIES_HALT |=> !fw_reg.we && $stable(acc_reg))
    else $error("instruction executed while halted");
  a_halt_wdog_hold: assert property (
    state_reg == CIES_HALT |=> $stable(wdog_reg) && $stable(pre_reg))
    else $error("watchdog moved while halted");
  a_nop_no_pop: assert property (
    exec_q && instr_in == IW_NOP && !push_in |=> $stable(sp_reg))
    else $error("nop moved the stack");
endmodule
`default_nettype wire

// [cies_pkg.sv]
package cies_pkg;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 7;
  localparam int PC_W     = 11;
  localparam int INSTR_W  = 14;
  localparam int STACK_D  = 8;
  localparam int WDOG_W   = 8;
  localparam int PRE_W    = 8;
  localparam int SP_W     = 3;
  localparam int BIT_MSB  = 7;
  localparam int D_BIT    = 7;
  localparam int OP_HI    = 13;
  localparam int OP_LO    = 8;
  // 6-bit major opcodes of the byte-oriented group
  localparam logic [5:0] OP_MOVE_OR_NOP = 6'h00;
  localparam logic [5:0] OP_IOR  = 6'h04;
  localparam logic [5:0] OP_MOVE_REG = 6'h08;
  localparam logic [5:0] OP_RRC  = 6'h0C;
  localparam logic [5:0] OP_RLC  = 6'h0D;
  localparam logic [3:0] OP_RETL = 4'hD;
  localparam logic [13:0] IW_NOP    = 14'h0000;
  localparam logic [13:0] IW_RETURN = 14'h0008;
  localparam logic [13:0] IW_RET_IRQ = 14'h0009;
  localparam logic [13:0] IW_SLEEP  = 14'h0063;
  localparam logic [PC_W-1:0]  PC_RESET  = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [WDOG_W-1:0] WDOG_CLEAR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
  localparam logic [SP_W-1:0]  SP_RESET  = 3'h0;

  typedef enum logic [1:0] {
    CIES_EXEC  = 2'b00,
    CIES_FLUSH = 2'b01,
    CIES_HALT  = 2'b11
  } cies_state_type;

  typedef struct packed {
    logic carry;
    logic zero;
    logic timeout_status_n;
    logic powerdown_status_n;
  } cies_flags_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              we;
  } cies_fwrite_type;
endpackage

// [cies_regfile_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_regfile_model (
  input  wire logic [cies_pkg::ADDR_W-1:0] raddr_in,
  input  wire logic                        clk_in,
  input  wire cies_pkg::cies_fwrite_type   wr_in,
  output logic [cies_pkg::DATA_W-1:0]      rdata_out
);
  import cies_pkg::*;
  // unwritten registers stay unknown, as in the real array
  logic [DATA_W-1:0] mem [0:127];
  // a write lands one edge after the core registers it, so reading the
  // same register in the very next instruction sees the old value
  always_ff @(posedge clk_in) begin
    if (wr_in.we) begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end
  assign rdata_out = mem[raddr_in];
endmodule
`default_nettype wire

// [test_cpu_instruction_execute_subset.sv]
`timescale 1ns/1ps
`default_nettype none
module test_cpu_instruction_execute_subset;
  import cies_pkg::*;
  logic                clk_in, rst_b_in, push_in, wake_in, irq_en, halted;
  logic [INSTR_W-1:0]  instr_in;
  logic [PC_W-1:0]     push_addr_in, pc_out, pcv;
  logic [ADDR_W-1:0]   raddr;
  logic [DATA_W-1:0]   rdata, acc_out;
  logic [WDOG_W-1:0]   wdog;
  logic [PRE_W-1:0]    pre;
  cies_fwrite_type     fwrite;
  cies_flags_type      flags;
  int                  failures, check_count;

  cies_core dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .instr_in(instr_in), .freg_rdata_in(rdata), .push_in(push_in),
    .push_addr_in(push_addr_in), .wake_in(wake_in), .pc_out(pc_out),
    .freg_raddr_out(raddr), .fwrite_out(fwrite), .acc_out(acc_out),
    .flags_out(flags), .global_irq_enable_out(irq_en),
    .watchdog_counter_out(wdog), .wdog_prescaler_out(pre),
    .halted_out(halted));
  cies_regfile_model mem_u (.raddr_in(raddr), .clk_in(clk_in),
    .wr_in(fwrite), .rdata_out(rdata));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // idle word is a no-op so no instruction is ever taken twice
  task automatic exec(input logic [INSTR_W-1:0] w);
    instr_in <= w;
    @(posedge clk_in);
    instr_in <= IW_NOP;
    #1;
  endtask
  task automatic push(input logic [PC_W-1:0] a);
    push_in <= 1'b1;
    push_addr_in <= a;
    @(posedge clk_in);
    push_in <= 1'b0;
    #1;
  endtask
  function automatic logic [13:0] fi(input logic [5:0] op, input logic d,
                                     input logic [6:0] f);
    return {op, d, f};
  endfunction

  // ----------------------------------------
  // clock, limit and sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    rst_b_in = 1'b0;
    push_in = 1'b0;
    wake_in = 1'b0;
    instr_in = IW_NOP;
    push_addr_in = '0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk(16'(flags), 16'h0003);
    push(11'h123);
    exec({OP_RETL, 2'b00, 8'h81});
    chk(acc_out, 16'h0081);
    chk({pc_out, flags}, {11'h123, 4'h3});
    exec(fi(OP_IOR, 1'b1, 7'h05));
    chk(fwrite.we, 16'h0000);
    exec(fi(OP_MOVE_OR_NOP, 1'b1, 7'h05));
    chk({fwrite, flags}, {7'h05, 8'h81, 1'b1, 4'h3});
    pcv = pc_out;
    exec(IW_NOP);
    chk(pc_out, pcv + 11'h001);
    chk({acc_out, flags, fwrite.we}, {8'h81, 4'h3, 1'b0});
    exec(fi(OP_MOVE_REG, 1'b0, 7'h05));
    chk({acc_out, flags}, {8'h81, 4'h3});
    push(11'h200);
    exec({OP_RETL, 2'b00, 8'h00});
    exec(IW_NOP);
    exec(fi(OP_MOVE_OR_NOP, 1'b1, 7'h06));
    exec(IW_NOP);
    exec(fi(OP_MOVE_REG, 1'b1, 7'h06));
    chk({fwrite, flags}, {7'h06, 8'h00, 1'b1, 4'h7});
    exec(fi(OP_IOR, 1'b0, 7'h05));
    chk({acc_out, flags}, {8'h81, 4'h3});
    exec(fi(OP_RLC, 1'b0, 7'h05));
    chk({acc_out, flags}, {8'h02, 4'hB});
    exec(fi(OP_RRC, 1'b0, 7'h05));
    chk({acc_out, flags}, {8'hC0, 4'hB});
    exec(fi(OP_RLC, 1'b1, 7'h06));
    chk({fwrite, flags}, {7'h06, 8'h01, 1'b1, 4'h3});
    exec(fi(OP_RRC, 1'b1, 7'h05));
    chk({fwrite, flags}, {7'h05, 8'h40, 1'b1, 4'hB});
    exec(fi(OP_IOR, 1'b1, 7'h06));
    chk({fwrite, acc_out}, {7'h06, 8'hC1, 1'b1, 8'hC0});
    push(11'h2AA);
    exec(IW_RETURN);
    chk({pc_out, flags}, {11'h2AA, 4'hB});
    exec(IW_NOP);
    push(11'h055);
    exec(IW_RET_IRQ);
    chk({pc_out, irq_en, flags}, {11'h055, 1'b1, 4'hB});
    exec(IW_NOP);
    exec(IW_SLEEP);
    chk({wdog, pre}, 16'h0000);
    chk(16'(flags), 16'h000A);
    chk(halted, 16'h0001);
    pcv = pc_out;
    exec(fi(OP_MOVE_REG, 1'b0, 7'h05));
    chk({pc_out, acc_out}, {pcv, 8'hC0});
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    #1;
    chk(halted, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
